/* File: verilog/tcdr_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module tcdr_regs #(
   parameter logic [7:0] TIMER_COUNT       = 8'h0a,
   parameter logic [7:0] CLOCK_BLOCK_COUNT = 8'h06
) (
   input  wire logic              mclk_in,
   input  wire logic              rstn_in,
   input  wire tcdr_pkg::tcdr_req_t net_req_in,
   input  wire tcdr_pkg::tcdr_req_t scr_req_in,
   input  wire tcdr_pkg::tcdr_req_t jtag_req_in,
   input  wire logic              in_debug_mode_in,
   input  wire logic [31:0]       pc_core0_in,
   input  wire logic              otp_load_in,
   input  wire logic [31:0]       otp_word_in,
   input  wire logic              divider_enable_in,
   output var  tcdr_pkg::tcdr_rsp_t net_rsp_out,
   output var  tcdr_pkg::tcdr_rsp_t scr_rsp_out,
   output var  tcdr_pkg::tcdr_rsp_t jtag_rsp_out,
   output logic                   debug_irq_out,
   output logic                   tile_clk_tick_out,
   output logic                   tile_clk_gate_out,
   output logic                   global_debug_block_out,
   output logic                   all_sector_lock_out,
   output logic [3:0]             per_sector_lock_out,
   output logic                   forced_otp_boot_out,
   output logic                   jtag_boot_cfg_block_out,
   output logic                   jtag_debug_port_block_out
);

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   logic [31:0]               guard_ff;
   logic [31:0]               nxt_guard;
   logic                      irq_ff;
   logic                      nxt_irq;
   logic                      in_dbg_ff;
   logic [31:0]               div_ff;
   logic [31:0]               nxt_div;
   logic [31:0]               sec_ff;
   logic [31:0]               nxt_sec;
   logic [31:0]               scratch_ff [tcdr_pkg::NUM_SCR];
   logic [31:0]               nxt_scratch [tcdr_pkg::NUM_SCR];
   tcdr_pkg::tcdr_req_t       req [tcdr_pkg::NUM_PORTS];
   tcdr_pkg::tcdr_rsp_t       rsp_ff [tcdr_pkg::NUM_PORTS];
   tcdr_pkg::tcdr_rsp_t       nxt_rsp [tcdr_pkg::NUM_PORTS];

   assign req[tcdr_pkg::PORT_NET]  = net_req_in;
   assign req[tcdr_pkg::PORT_SCR]  = scr_req_in;
   assign req[tcdr_pkg::PORT_JTAG] = jtag_req_in;

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   // the scratch path sees only the processor status scratch view,
   // indexed 0..7; other ports use the tile register numbers
   function automatic logic [7:0] map_addr(input int unsigned p, input logic [7:0] a);
      logic [7:0] m;
      m = a;
      if (p == tcdr_pkg::PORT_SCR) begin
         m = (a < 8'(tcdr_pkg::NUM_SCR)) ? (tcdr_pkg::ADDR_SCR0 + a) : 8'hff;
      end
      return m;
   endfunction

   function automatic logic is_scr(input logic [7:0] a);
      return (a >= tcdr_pkg::ADDR_SCR0) && (a <= tcdr_pkg::ADDR_SCR7);
   endfunction

   function automatic logic is_writable(input logic [7:0] a);
      return (a == tcdr_pkg::ADDR_GRD) || (a == tcdr_pkg::ADDR_DINT) ||
             (a == tcdr_pkg::ADDR_DIV) || is_scr(a);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      return is_writable(a) || (a == tcdr_pkg::ADDR_RES) ||
             (a == tcdr_pkg::ADDR_SEC) || (a == tcdr_pkg::ADDR_PC0);
   endfunction

   // ---------------------------------------------------------------
   // register next values and answers
   // ---------------------------------------------------------------
   // all three ports are served in the same cycle; colliding writes
   // resolve network, then scratch path, then jtag, the last one wins
   always_comb begin
      logic [7:0]  a;
      logic        blocked;
      logic [31:0] rd;
      a         = 8'h00;
      blocked   = 1'b0;
      rd        = 32'h0000_0000;
      nxt_guard = guard_ff;
      nxt_div   = div_ff;
      nxt_sec   = sec_ff;
      nxt_irq   = irq_ff;
      for (int i = 0; i < tcdr_pkg::NUM_SCR; i++) begin
         nxt_scratch[i] = scratch_ff[i];
      end
      // the copy reloads only while its own lock bit is clear
      if (otp_load_in && !sec_ff[tcdr_pkg::SEC_WLOCK]) begin
         nxt_sec = otp_word_in & tcdr_pkg::SEC_MASK;
      end
      // the request is cleared here once the processor has entered debug mode
      if (in_dbg_ff) begin
         nxt_irq = 1'b0;
      end
      for (int p = 0; p < tcdr_pkg::NUM_PORTS; p++) begin
         a       = map_addr(p, req[p].addr);
         blocked = guard_ff[tcdr_pkg::GRD_ALL_RO];
         if (p == tcdr_pkg::PORT_NET && guard_ff[tcdr_pkg::GRD_NET_RO]) begin
            blocked = 1'b1;
         end
         if (p == tcdr_pkg::PORT_JTAG && sec_ff[tcdr_pkg::SEC_JBOOT] &&
             a == tcdr_pkg::ADDR_DIV) begin
            blocked = 1'b1;
         end
         case (a)
            tcdr_pkg::ADDR_RES:  rd = {16'h0000, CLOCK_BLOCK_COUNT, TIMER_COUNT};
            tcdr_pkg::ADDR_GRD:  rd = guard_ff;
            tcdr_pkg::ADDR_DINT: rd = {30'h0000_0000, in_dbg_ff, irq_ff};
            tcdr_pkg::ADDR_DIV:  rd = div_ff;
            tcdr_pkg::ADDR_SEC:  rd = sec_ff;
            tcdr_pkg::ADDR_PC0:  rd = pc_core0_in;
            default:             rd = is_scr(a) ? scratch_ff[a[2:0]] : 32'h0000_0000;
         endcase
         nxt_rsp[p].ack     = req[p].valid;
         nxt_rsp[p].rdata   = (req[p].valid && !req[p].write) ? rd : 32'h0000_0000;
         nxt_rsp[p].refused = req[p].valid &&
                              (!is_mapped(a) || (req[p].write && (!is_writable(a) || blocked)));
         if (req[p].valid && req[p].write && is_writable(a) && !blocked) begin
            case (a)
               tcdr_pkg::ADDR_GRD:  nxt_guard = req[p].wdata & tcdr_pkg::GRD_MASK;
               tcdr_pkg::ADDR_DIV:  nxt_div   = req[p].wdata & tcdr_pkg::DIV_MASK;
               tcdr_pkg::ADDR_DINT: begin
                  // a fresh request wins over the debug-mode clear
                  if (req[p].wdata[tcdr_pkg::DINT_REQ]) begin
                     nxt_irq = 1'b1;
                  end
               end
               default:             nxt_scratch[a[2:0]] = req[p].wdata;
            endcase
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         guard_ff  <= tcdr_pkg::GRD_RST;
         div_ff    <= tcdr_pkg::DIV_RST;
         sec_ff    <= tcdr_pkg::SEC_RST;
         irq_ff    <= 1'b0;
         in_dbg_ff <= 1'b0;
         for (int i = 0; i < tcdr_pkg::NUM_SCR; i++) begin
            scratch_ff[i] <= tcdr_pkg::SCR_RST;
         end
         for (int p = 0; p < tcdr_pkg::NUM_PORTS; p++) begin
            rsp_ff[p] <= '0;
         end
      end else begin
         guard_ff  <= nxt_guard;
         div_ff    <= nxt_div;
         sec_ff    <= nxt_sec;
         irq_ff    <= nxt_irq;
         in_dbg_ff <= in_debug_mode_in;
         for (int i = 0; i < tcdr_pkg::NUM_SCR; i++) begin
            scratch_ff[i] <= nxt_scratch[i];
         end
         for (int p = 0; p < tcdr_pkg::NUM_PORTS; p++) begin
            rsp_ff[p] <= nxt_rsp[p];
         end
      end
   end

   // ---------------------------------------------------------------
   // tile clock divider
   // ---------------------------------------------------------------
   // the tile clock is delivered as a one-cycle tick so that no gated
   // clock leaves this block; divide values 0 and 1 both mean full rate
   logic [tcdr_pkg::DIV_W-1:0] div_cnt_ff;
   logic [tcdr_pkg::DIV_W-1:0] nxt_div_cnt;
   logic                       tick_ff;
   logic                       nxt_tick;

   always_comb begin
      nxt_div_cnt = 16'h0000;
      nxt_tick    = 1'b1;
      if (div_ff[tcdr_pkg::DIV_GATE]) begin
         nxt_tick = 1'b0;
      end else if (divider_enable_in && div_ff[15:0] > 16'h0001) begin
         nxt_tick    = (div_cnt_ff == 16'h0000);
         nxt_div_cnt = (div_cnt_ff >= div_ff[15:0] - 16'h0001) ? 16'h0000
                                                                : div_cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_cnt_ff <= 16'h0000;
         tick_ff    <= 1'b0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
         tick_ff    <= nxt_tick;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign net_rsp_out               = rsp_ff[tcdr_pkg::PORT_NET];
   assign scr_rsp_out               = rsp_ff[tcdr_pkg::PORT_SCR];
   assign jtag_rsp_out              = rsp_ff[tcdr_pkg::PORT_JTAG];
   assign debug_irq_out             = irq_ff;
   assign tile_clk_tick_out         = tick_ff;
   assign tile_clk_gate_out         = div_ff[tcdr_pkg::DIV_GATE];
   assign global_debug_block_out    = sec_ff[tcdr_pkg::SEC_GDBG];
   assign all_sector_lock_out       = sec_ff[tcdr_pkg::SEC_ALLLK];
   assign per_sector_lock_out       = sec_ff[tcdr_pkg::SEC_SECLK +: 4];
   assign forced_otp_boot_out       = sec_ff[tcdr_pkg::SEC_BOOT];
   assign jtag_boot_cfg_block_out   = sec_ff[tcdr_pkg::SEC_JBOOT];
   assign jtag_debug_port_block_out = sec_ff[tcdr_pkg::SEC_JDBG];

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   property p_res_read;
      @(posedge mclk_in) disable iff (!rstn_in)
      (net_req_in.valid && !net_req_in.write && net_req_in.addr == tcdr_pkg::ADDR_RES)
      |=> (net_rsp_out.rdata == {16'h0000, CLOCK_BLOCK_COUNT, TIMER_COUNT}) && !net_rsp_out.refused;
   endproperty
   a_res_read: assert property (p_res_read) else $error("resource word wrong");

   property p_net_ro;
      @(posedge mclk_in) disable iff (!rstn_in)
      (net_req_in.valid && net_req_in.write && net_req_in.addr == tcdr_pkg::ADDR_DIV &&
       guard_ff[tcdr_pkg::GRD_NET_RO] && !jtag_req_in.valid)
      |=> net_rsp_out.refused && $stable(div_ff);
   endproperty
   a_net_ro: assert property (p_net_ro) else $error("network write passed guard");

   property p_all_ro;
      @(posedge mclk_in) disable iff (!rstn_in)
      guard_ff[tcdr_pkg::GRD_ALL_RO] && !otp_load_in && !in_dbg_ff
      |=> $stable(guard_ff) && $stable(div_ff) && $stable(irq_ff);
   endproperty
   a_all_ro: assert property (p_all_ro) else $error("write passed full guard");

   property p_guard_rst;
      @(posedge mclk_in) $rose(rstn_in) |-> guard_ff == 32'h0000_0000;
   endproperty
   a_guard_rst: assert property (p_guard_rst) else $error("guard not cleared");

   property p_irq_req;
      @(posedge mclk_in) disable iff (!rstn_in)
      (jtag_req_in.valid && jtag_req_in.write && jtag_req_in.addr == tcdr_pkg::ADDR_DINT &&
       jtag_req_in.wdata[0] && !guard_ff[tcdr_pkg::GRD_ALL_RO])
      |=> debug_irq_out ##0 jtag_rsp_out.ack;
   endproperty
   a_irq_req: assert property (p_irq_req) else $error("debug request lost");

   property p_in_dbg;
      @(posedge mclk_in) disable iff (!rstn_in)
      in_debug_mode_in[*2] ##0 (net_req_in.valid && !net_req_in.write &&
                               net_req_in.addr == tcdr_pkg::ADDR_DINT)
      |=> net_rsp_out.rdata[1];
   endproperty
   a_in_dbg: assert property (p_in_dbg) else $error("debug mode flag wrong");

   logic div3_run;
   assign div3_run = divider_enable_in && div_ff[15:0] == 16'h0003 && !div_ff[tcdr_pkg::DIV_GATE];

   property p_div_gap;
      @(posedge mclk_in) disable iff (!rstn_in)
      div3_run ##1 (div3_run && tick_ff) ##1 div3_run[*2] |-> !tick_ff ##1 tick_ff;
   endproperty
   a_div_gap: assert property (p_div_gap) else $error("divider rate wrong");

   property p_undiv;
      @(posedge mclk_in) disable iff (!rstn_in)
      !divider_enable_in && !div_ff[31] |=> tile_clk_tick_out;
   endproperty
   a_undiv: assert property (p_undiv) else $error("tick missing without enable");

   property p_gate;
      @(posedge mclk_in) disable iff (!rstn_in)
      div_ff[tcdr_pkg::DIV_GATE] |=> !tile_clk_tick_out;
   endproperty
   a_gate: assert property (p_gate) else $error("tick while gated");

   property p_sec_lock;
      @(posedge mclk_in) disable iff (!rstn_in)
      sec_ff[tcdr_pkg::SEC_WLOCK] |=> $stable(sec_ff);
   endproperty
   a_sec_lock: assert property (p_sec_lock) else $error("locked security word changed");

   property p_alias;
      @(posedge mclk_in) disable iff (!rstn_in)
      (scr_req_in.valid && scr_req_in.write && scr_req_in.addr == 8'h03 && !net_req_in.valid &&
       !jtag_req_in.valid && !guard_ff[tcdr_pkg::GRD_ALL_RO])
      |=> scratch_ff[3] == $past(scr_req_in.wdata);
   endproperty
   a_alias: assert property (p_alias) else $error("scratch alias broken");

   property p_pc_read;
      @(posedge mclk_in) disable iff (!rstn_in)
      (net_req_in.valid && !net_req_in.write && net_req_in.addr == tcdr_pkg::ADDR_PC0)
      |=> net_rsp_out.rdata == $past(pc_core0_in);
   endproperty
   a_pc_read: assert property (p_pc_read) else $error("core 0 pc read wrong");

   property p_gdbg_pin;
      @(posedge mclk_in) disable iff (!rstn_in)
      otp_load_in && !sec_ff[tcdr_pkg::SEC_WLOCK] && otp_word_in[tcdr_pkg::SEC_GDBG] |=> global_debug_block_out;
   endproperty
   a_gdbg_pin: assert property (p_gdbg_pin) else $error("global debug block missing");

   property p_all_lock_pin;
      @(posedge mclk_in) disable iff (!rstn_in)
      otp_load_in && !sec_ff[tcdr_pkg::SEC_WLOCK] && otp_word_in[tcdr_pkg::SEC_ALLLK] |=> all_sector_lock_out;
   endproperty
   a_all_lock_pin: assert property (p_all_lock_pin) else $error("all sector lock missing");

   property p_sector_pin;
      @(posedge mclk_in) disable iff (!rstn_in)
      otp_load_in && !sec_ff[tcdr_pkg::SEC_WLOCK] && otp_word_in[tcdr_pkg::SEC_SECLK] |=> per_sector_lock_out[0];
   endproperty
   a_sector_pin: assert property (p_sector_pin) else $error("sector lock missing");

   property p_boot_pin;
      @(posedge mclk_in) disable iff (!rstn_in)
      otp_load_in && !sec_ff[tcdr_pkg::SEC_WLOCK] && otp_word_in[tcdr_pkg::SEC_BOOT] |=> forced_otp_boot_out;
   endproperty
   a_boot_pin: assert property (p_boot_pin) else $error("forced boot missing");

   property p_jtag_cfg;
      @(posedge mclk_in) disable iff (!rstn_in)
      jtag_req_in.valid && jtag_req_in.write && jtag_req_in.addr == tcdr_pkg::ADDR_DIV &&
      sec_ff[tcdr_pkg::SEC_JBOOT] |=> jtag_rsp_out.refused;
   endproperty
   a_jtag_cfg: assert property (p_jtag_cfg) else $error("jtag divider write passed");

   property p_jdbg_pin;
      @(posedge mclk_in) disable iff (!rstn_in)
      otp_load_in && !sec_ff[tcdr_pkg::SEC_WLOCK] && otp_word_in[tcdr_pkg::SEC_JDBG] |=> jtag_debug_port_block_out;
   endproperty
   a_jdbg_pin: assert property (p_jdbg_pin) else $error("jtag debug block missing");

   property p_scr_read;
      @(posedge mclk_in) disable iff (!rstn_in)
      net_req_in.valid && !net_req_in.write && net_req_in.addr >= tcdr_pkg::ADDR_SCR0 &&
      net_req_in.addr <= tcdr_pkg::ADDR_SCR7 |=> net_rsp_out.ack && !net_rsp_out.refused;
   endproperty
   a_scr_read: assert property (p_scr_read) else $error("scratch read refused");

   property p_rsvd_zero;
      @(posedge mclk_in) disable iff (!rstn_in)
      (guard_ff & ~tcdr_pkg::GRD_MASK) == 32'h0000_0000 && (div_ff & ~tcdr_pkg::DIV_MASK) == 32'h0000_0000 &&
      (sec_ff & ~tcdr_pkg::SEC_MASK) == 32'h0000_0000;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

endmodule
`default_nettype wire

/* File: verilog/tcdr_pkg.sv */
`default_nettype none
package tcdr_pkg;
   localparam int unsigned DW        = 32;
   localparam int unsigned AW        = 8;
   localparam int unsigned NUM_SCR   = 8;
   localparam int unsigned NUM_PORTS = 3;
   localparam int unsigned PORT_NET  = 0;
   localparam int unsigned PORT_SCR  = 1;
   localparam int unsigned PORT_JTAG = 2;
   localparam int unsigned DIV_W     = 16;

   localparam logic [7:0] ADDR_RES  = 8'h02;
   localparam logic [7:0] ADDR_GRD  = 8'h04;
   localparam logic [7:0] ADDR_DINT = 8'h05;
   localparam logic [7:0] ADDR_DIV  = 8'h06;
   localparam logic [7:0] ADDR_SEC  = 8'h07;
   localparam logic [7:0] ADDR_SCR0 = 8'h20;
   localparam logic [7:0] ADDR_SCR7 = 8'h27;
   localparam logic [7:0] ADDR_PC0  = 8'h40;

   localparam int unsigned GRD_NET_RO = 0;
   localparam int unsigned GRD_ALL_RO = 31;
   localparam int unsigned DINT_REQ   = 0;
   localparam int unsigned DINT_INDBG = 1;
   localparam int unsigned DIV_GATE   = 31;
   localparam int unsigned SEC_WLOCK  = 31;
   localparam int unsigned SEC_GDBG   = 14;
   localparam int unsigned SEC_ALLLK  = 12;
   localparam int unsigned SEC_SECLK  = 8;
   localparam int unsigned SEC_BOOT   = 5;
   localparam int unsigned SEC_JBOOT  = 4;
   localparam int unsigned SEC_JDBG   = 0;

   localparam logic [31:0] GRD_MASK = 32'h8000_0001;
   localparam logic [31:0] DIV_MASK = 32'h8000_ffff;
   localparam logic [31:0] SEC_MASK = 32'h8000_5fb1;
   localparam logic [31:0] GRD_RST  = 32'h0000_0000;
   localparam logic [31:0] DIV_RST  = 32'h0000_0000;
   localparam logic [31:0] SEC_RST  = 32'h0000_0000;
   localparam logic [31:0] SCR_RST  = 32'h0000_0000;

   typedef struct packed {
      logic          valid;
      logic          write;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
   } tcdr_req_t;

   typedef struct packed {
      logic          ack;
      logic          refused;
      logic [DW-1:0] rdata;
   } tcdr_rsp_t;
endpackage
`default_nettype wire

/* File: dv/tcdr_proc_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// processor side of the tile
// ------------------------------------------------
module tcdr_proc_model (
   input  wire logic        mclk_in,
   input  wire logic        rstn_in,
   input  wire logic        debug_irq_in,
   output logic             in_debug_mode_out,
   output logic [31:0]      pc_core0_out
);
   logic [4:0] dbg_cnt_ff;

   // slow on purpose: the request has to stay up until debug mode is really entered
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dbg_cnt_ff        <= 5'h00;
         in_debug_mode_out <= 1'b0;
         pc_core0_out      <= 32'h0000_1000;
      end else begin
         pc_core0_out <= pc_core0_out + 32'h0000_0004;
         if (in_debug_mode_out) begin
            dbg_cnt_ff <= dbg_cnt_ff + 5'h01;
            if (dbg_cnt_ff == 5'h0f) begin
               in_debug_mode_out <= 1'b0;
               dbg_cnt_ff        <= 5'h00;
            end
         end else if (debug_irq_in) begin
            dbg_cnt_ff <= dbg_cnt_ff + 5'h01;
            if (dbg_cnt_ff == 5'h02) begin
               in_debug_mode_out <= 1'b1;
               dbg_cnt_ff        <= 5'h00;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: dv/tcdr_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tcdr_regs_tb;
   localparam logic [7:0] NT = 8'h11;
   localparam logic [7:0] NC = 8'h03;
   localparam int         NET = 0;
   localparam int         SCR = 1;
   localparam int         JTG = 2;
   logic                mclk_in = 1'b0;
   logic                rstn_in = 1'b0;
   tcdr_pkg::tcdr_req_t req [3];
   tcdr_pkg::tcdr_rsp_t rsp [3];
   tcdr_pkg::tcdr_rsp_t rsp_pc;
   logic                in_dbg, irq, tick, gate, otp_load, div_en;
   logic [31:0]         pc0, otp_word, pc_take, s, w;
   logic [8:0]          sec_o;
   int                  errors = 0;
   int                  checks_done = 0;
   int                  k, c;

   always #4 mclk_in = ~mclk_in;

   tcdr_regs #(.TIMER_COUNT(NT), .CLOCK_BLOCK_COUNT(NC)) u_tcdr_regs (
      .mclk_in(mclk_in), .rstn_in(rstn_in), .net_req_in(req[0]), .scr_req_in(req[1]),
      .jtag_req_in(req[2]), .in_debug_mode_in(in_dbg), .pc_core0_in(pc0), .otp_load_in(otp_load),
      .otp_word_in(otp_word), .divider_enable_in(div_en), .net_rsp_out(rsp[0]), .scr_rsp_out(rsp[1]),
      .jtag_rsp_out(rsp[2]), .debug_irq_out(irq), .tile_clk_tick_out(tick), .tile_clk_gate_out(gate),
      .global_debug_block_out(sec_o[8]), .all_sector_lock_out(sec_o[7]), .per_sector_lock_out(sec_o[6:3]),
      .forced_otp_boot_out(sec_o[2]), .jtag_boot_cfg_block_out(sec_o[1]), .jtag_debug_port_block_out(sec_o[0]));

   tcdr_proc_model u_tcdr_proc_model (
      .mclk_in(mclk_in), .rstn_in(rstn_in), .debug_irq_in(irq), .in_debug_mode_out(in_dbg),
      .pc_core0_out(pc0));

   // ------------------------------------------------
   // expectations and checking
   // ------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic [8:0] sec_pins(input logic [31:0] v);
      return {v[14], v[12], v[11:8], v[5], v[4], v[0]};
   endfunction

   task automatic end_of_test();
      $display("checks_done=%0d errors=%0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // ------------------------------------------------
   // register access, entered just after a rising edge
   // ------------------------------------------------
   task automatic acc(input int p, input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                      output tcdr_pkg::tcdr_rsp_t r);
      int n;
      req[p] <= '{valid: 1'b1, write: wr_en, addr: a, wdata: d};
      @(posedge mclk_in);
      pc_take = pc0;
      req[p] <= '0;
      r = '0;
      for (n = 0; n < 4 && r.ack !== 1'b1; n++) begin
         @(posedge mclk_in);
         r = rsp[p];
      end
      if (r.ack !== 1'b1) begin
         errors++;
         end_of_test();
      end
   endtask

   task automatic wr(input int p, input logic [7:0] a, input logic [31:0] d, input logic ref_exp);
      tcdr_pkg::tcdr_rsp_t r;
      acc(p, 1'b1, a, d, r);
      chk("refused", {31'h0, r.refused}, {31'h0, ref_exp});
   endtask

   task automatic rd(input int p, input logic [7:0] a, input logic [31:0] exp);
      tcdr_pkg::tcdr_rsp_t r;
      acc(p, 1'b0, a, 32'h0, r);
      chk("refused", {31'h0, r.refused}, 32'h0);
      chk("rdata", r.rdata, exp);
   endtask

   task automatic otp(input logic [31:0] v);
      otp_load <= 1'b1;
      otp_word <= v;
      @(posedge mclk_in);
      otp_load <= 1'b0;
      repeat (3) @(posedge mclk_in);
   endtask

   task automatic ticks(input int n, output int cnt);
      cnt = 0;
      repeat (n) begin
         @(posedge mclk_in);
         cnt += (tick === 1'b1) ? 1 : 0;
      end
   endtask

   task automatic do_reset();
      rstn_in <= 1'b0;
      repeat (20) @(posedge mclk_in);
      rstn_in <= 1'b1;
      @(posedge mclk_in);
   endtask

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      req[0] <= '0;
      req[1] <= '0;
      req[2] <= '0;
      otp_load <= 1'b0;
      otp_word <= 32'h0;
      div_en <= 1'b0;
      s = 32'h0000_003a;
      do_reset();
      rd(NET, 8'h02, {16'h0, NC, NT});
      wr(NET, 8'h02, 32'hffff_ffff, 1'b1);
      rd(JTG, 8'h04, 32'h0);
      rd(NET, 8'h05, 32'h0);
      rd(NET, 8'h06, 32'h0);
      rd(NET, 8'h07, 32'h0);
      wr(NET, 8'h03, 32'h1, 1'b1);
      wr(NET, 8'h41, 32'h1, 1'b1);
      wr(SCR, 8'h08, 32'h1, 1'b1);
      acc(NET, 1'b0, 8'h40, 32'h0, rsp_pc);
      chk("pc0", rsp_pc.rdata, pc_take);
      chk("pc0_refused", {31'h0, rsp_pc.refused}, 32'h0);
      wr(JTG, 8'h40, 32'h0, 1'b1);
      wr(JTG, 8'h05, 32'h1, 1'b0);
      chk("irq", {31'h0, irq}, 32'h1);
      repeat (7) @(posedge mclk_in);
      rd(NET, 8'h05, 32'h2);
      chk("irq", {31'h0, irq}, 32'h0);
      repeat (30) @(posedge mclk_in);
      rd(NET, 8'h05, 32'h0);
      for (k = 0; k < 8; k++) begin
         s = lfsr(s);
         wr(k[0] ? NET : JTG, 8'h20 + k[7:0], s, 1'b0);
         rd(SCR, k[7:0], s);
         s = lfsr(s);
         wr(SCR, k[7:0], s, 1'b0);
         rd(k[0] ? JTG : NET, 8'h20 + k[7:0], s);
      end
      wr(NET, 8'h06, 32'h8000_0003, 1'b0);
      repeat (2) @(posedge mclk_in);
      ticks(20, c);
      chk("ticks", c, 32'h0000_0000);
      chk("gate", {31'h0, gate}, 32'h1);
      rd(NET, 8'h06, 32'h8000_0003);
      wr(NET, 8'h06, 32'h7fff_0003, 1'b0);
      rd(NET, 8'h06, 32'h0000_0003);
      div_en <= 1'b1;
      repeat (10) @(posedge mclk_in);
      ticks(48, c);
      chk("ticks", c, 32'h0000_0010);
      div_en <= 1'b0;
      repeat (4) @(posedge mclk_in);
      ticks(50, c);
      chk("ticks", c, 32'h0000_0032);
      for (k = 0; k < 5; k++) begin
         s = lfsr(s);
         w = (k == 4) ? (s | 32'h8000_0010) : (s & 32'h7fff_ffff);
         otp(w);
         rd(JTG, 8'h07, w & tcdr_pkg::SEC_MASK);
         chk("sec_pins", {23'h0, sec_o}, {23'h0, sec_pins(w)});
      end
      otp(~w);
      rd(NET, 8'h07, w & tcdr_pkg::SEC_MASK);
      wr(NET, 8'h07, 32'h0, 1'b1);
      wr(JTG, 8'h06, 32'h0, 1'b1);
      wr(NET, 8'h06, 32'h0, 1'b0);
      wr(NET, 8'h04, 32'h7fff_fffe, 1'b0);
      rd(NET, 8'h04, 32'h0);
      wr(NET, 8'h04, 32'h1, 1'b0);
      rd(NET, 8'h04, 32'h1);
      wr(NET, 8'h06, 32'h1, 1'b1);
      wr(NET, 8'h20, 32'h1234_5678, 1'b1);
      wr(SCR, 8'h00, 32'h0bad_cafe, 1'b0);
      wr(JTG, 8'h21, 32'h5a5a_0001, 1'b0);
      wr(NET, 8'h04, 32'h0, 1'b1);
      wr(JTG, 8'h04, 32'h0, 1'b0);
      wr(JTG, 8'h04, 32'h8000_0000, 1'b0);
      wr(NET, 8'h20, 32'h1, 1'b1);
      wr(SCR, 8'h00, 32'h1, 1'b1);
      wr(JTG, 8'h21, 32'h1, 1'b1);
      wr(JTG, 8'h05, 32'h1, 1'b1);
      rd(NET, 8'h20, 32'h0bad_cafe);
      rd(NET, 8'h21, 32'h5a5a_0001);
      do_reset();
      rd(NET, 8'h04, 32'h0);
      wr(NET, 8'h22, 32'h7, 1'b0);
      end_of_test();
   end
endmodule
`default_nettype wire
